// ### rtl/sib_core.sv
// serial interface core: mode decode, baud source, uart and three-wire shifter
// assumes synchronous pin inputs and a one-cycle-latency register port
// Overview of operation
// - three-wire when both uart enables 0 and enable set; direction bit picks first bit
// - uart needs three-wire bits zero; enables pick tx, rx or both; lsb first
// - external baud pin is a clock only when selected in uart, else port pin except in three-wire mode
// - three-wire serial input pin is never driven, free as port line
// - status reports receive errors in uart mode, undefined in three-wire mode
// - reset clears the error status to zero
// - parity flag set on mismatch with configured odd or even parity, cleared otherwise
// - framing flag set when stop bit missing, cleared otherwise
// - receiver checks one stop bit even with two configured
// - overrun flag set when a character completes before buffer read
// - overrun repeats on every reception until the buffer is read
// - baud source in bits 7..4, low bits zero; codes 0..7 divide by 2^(n+1)
// - code 8 selects external pin clock, only in uart mode
// - bit clock derives from divided system clock or external pin clock
// - parity modes: none, zero without check, odd, even
// - internal source bit rate is system clock over 2^(n+1) times 16
// - external source bit rate is pin clock over 16
// - internal three-wire clock is system clock over 2^(n+2)
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module sib_core (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire sib_pkg::sib_bus_s reg_bus,
  output logic [7:0]             reg_rdata,
  input  wire logic              rx_line,
  input  wire logic              ext_baud_clk_pin,
  input  wire logic              serial_clk_in,
  output logic                   serial_clk_out,
  output logic                   serial_clk_oe,
  output logic                   tx_line_out,
  output logic                   tx_line_oe,
  output logic [2:0]             port_free,
  output logic                   mode_err
);
  sib_pkg::sib_state_s q;
  sib_pkg::sib_state_s next_q;
  logic       tw;
  logic       uart;
  logic       idle_mode;
  logic       tx_on;
  logic       rx_on;
  logic [3:0] code;
  logic [7:0] mask;
  logic       int_tick;
  logic       ext_rise;
  logic       src_tick;
  logic       rd_buf;
  logic       wr_data;
  logic       bit_smp;
  logic       rx_done;
  logic       tw_rise;
  logic       tw_fall;
  logic [1:0] ps;
  logic       cl;
  logic       csck;

  assign code = q.baud[7:4];
  assign ps   = q.async_mode[sib_pkg::PS_LSB +: 2];
  assign cl   = q.async_mode[sib_pkg::CL_BIT];
  assign csck = q.tw_mode[sib_pkg::CSCK_BIT];
  assign tw = q.tw_mode[sib_pkg::CSIE_BIT] && !q.async_mode[sib_pkg::TXE_BIT]
              && !q.async_mode[sib_pkg::RXE_BIT];
  assign uart = (q.tw_mode == sib_pkg::REG_RST)
                && (q.async_mode[sib_pkg::TXE_BIT] || q.async_mode[sib_pkg::RXE_BIT]);
  assign idle_mode = (q.tw_mode == sib_pkg::REG_RST) && (q.async_mode == sib_pkg::REG_RST);
  assign tx_on = uart && q.async_mode[sib_pkg::TXE_BIT];
  assign rx_on = uart && q.async_mode[sib_pkg::RXE_BIT];
  // invalid mode combinations, codes above 8, and external source in three-wire
  assign mode_err = !(tw || uart || idle_mode) || (code > sib_pkg::BAUD_EXT)
                    || (tw && code == sib_pkg::BAUD_EXT);

  // internal source ticks once per 2^(code+1) clocks
  assign mask     = 8'((9'h002 << code[2:0]) - 9'h001);
  assign int_tick = !code[3] && ((q.presc & mask) == mask);
  assign ext_rise = uart && (code == sib_pkg::BAUD_EXT) && ext_baud_clk_pin && !q.ext_q;
  assign src_tick = int_tick || ext_rise;

  assign rd_buf  = reg_bus.rd && reg_bus.addr == sib_pkg::OFS_DATA;
  assign wr_data = reg_bus.wr && reg_bus.addr == sib_pkg::OFS_DATA;
  assign bit_smp = src_tick && q.rx_cnt == sib_pkg::OVS_LAST;
  assign rx_done = bit_smp && q.rx_st == sib_pkg::RX_STOP;
  // edges of the selected shift clock
  assign tw_rise = csck ? (src_tick && q.tw_busy && !q.sck_int) : (!q.sck_q && serial_clk_in);
  assign tw_fall = csck ? (src_tick && q.tw_busy && q.sck_int) : (q.sck_q && !serial_clk_in);

  always_comb begin
    logic [11:0] fr;
    logic [7:0]  dv;
    logic        par;
    logic [7:0]  sh;
    fr     = 12'hFFF;
    dv     = cl ? reg_bus.wdata : {1'b0, reg_bus.wdata[6:0]};
    par    = 1'b0;
    sh     = 8'h00;
    next_q = q;
    next_q.presc = q.presc + 8'h01;
    next_q.ext_q = ext_baud_clk_pin;
    next_q.sck_q = serial_clk_in;
    next_q.rdata = 8'h00;
    if (reg_bus.rd) begin
      case (reg_bus.addr)
        sib_pkg::OFS_ASYNC: next_q.rdata = q.async_mode;
        sib_pkg::OFS_STAT:  next_q.rdata = {5'h00, q.stat};
        sib_pkg::OFS_3W:    next_q.rdata = q.tw_mode;
        sib_pkg::OFS_BAUD:  next_q.rdata = q.baud;
        sib_pkg::OFS_DATA:  next_q.rdata = q.rxbuf;
        default:            next_q.rdata = 8'h00;
      endcase
    end
    if (reg_bus.wr) begin
      case (reg_bus.addr)
        sib_pkg::OFS_ASYNC: next_q.async_mode = reg_bus.wdata & sib_pkg::ASYNC_MASK;
        sib_pkg::OFS_3W:    next_q.tw_mode = reg_bus.wdata & sib_pkg::TW_MASK;
        sib_pkg::OFS_BAUD:  next_q.baud = reg_bus.wdata & sib_pkg::BAUD_MASK;
        default:            next_q.rdata = next_q.rdata;
      endcase
    end
    // only a buffer read clears the full flag
    if (rd_buf) begin
      next_q.rx_full = 1'b0;
    end

    // uart receiver
    if (src_tick && q.rx_st != sib_pkg::RX_IDLE) begin
      next_q.rx_cnt = q.rx_cnt + 4'h1;
    end
    unique case (q.rx_st)
      sib_pkg::RX_IDLE: begin
        if (rx_on && !rx_line) begin
          next_q.rx_st  = sib_pkg::RX_START;
          next_q.rx_cnt = 4'h0;
        end
      end
      sib_pkg::RX_START: begin
        if (src_tick && q.rx_cnt == sib_pkg::OVS_MID) begin
          next_q.rx_cnt  = 4'h0;
          next_q.rx_bit  = 4'h0;
          next_q.rx_par  = 1'b0;
          next_q.pe_pend = 1'b0;
          next_q.rx_st   = rx_line ? sib_pkg::RX_IDLE : sib_pkg::RX_DATA;
        end
      end
      sib_pkg::RX_DATA: begin
        if (bit_smp) begin
          next_q.rx_sh  = {rx_line, q.rx_sh[7:1]};
          next_q.rx_par = q.rx_par ^ rx_line;
          next_q.rx_bit = q.rx_bit + 4'h1;
          if (q.rx_bit == (cl ? 4'h7 : 4'h6)) begin
            next_q.rx_st = (ps != sib_pkg::PAR_NONE) ? sib_pkg::RX_PAR : sib_pkg::RX_STOP;
          end
        end
      end
      sib_pkg::RX_PAR: begin
        if (bit_smp) begin
          next_q.pe_pend = (ps == sib_pkg::PAR_ODD)  ? !(q.rx_par ^ rx_line) :
                           (ps == sib_pkg::PAR_EVEN) ?  (q.rx_par ^ rx_line) : 1'b0;
          next_q.rx_st   = sib_pkg::RX_STOP;
        end
      end
      sib_pkg::RX_STOP: begin
        // flags replaced together; one stop bit; overrun
        if (bit_smp) begin
          next_q.stat[sib_pkg::PE_BIT]  = q.pe_pend;
          next_q.stat[sib_pkg::FE_BIT]  = !rx_line;
          next_q.stat[sib_pkg::OVE_BIT] = q.rx_full && !rd_buf;
          next_q.rxbuf   = cl ? q.rx_sh : {1'b0, q.rx_sh[7:1]};
          next_q.rx_full = 1'b1;
          next_q.rx_st   = sib_pkg::RX_IDLE;
        end
      end
    endcase
    if (!rx_on) begin
      next_q.rx_st = sib_pkg::RX_IDLE;
    end

    // uart transmitter: frame shifts out of bit 0
    if (cl) begin
      fr[8:1] = dv;
    end else begin
      fr[7:1] = dv[6:0];
    end
    fr[0] = 1'b0;
    // zero, odd or even parity bit
    par = (ps == sib_pkg::PAR_ODD) ? !(^dv) : (ps == sib_pkg::PAR_EVEN) ? (^dv) : 1'b0;
    if (ps != sib_pkg::PAR_NONE) begin
      fr[cl ? 9 : 8] = par;
    end
    if (wr_data && tx_on && !q.tx_busy) begin
      next_q.tx_sh   = fr;
      next_q.tx_busy = 1'b1;
      next_q.tx_cnt  = 4'h0;
      next_q.tx_left = 4'(4'h2 + (cl ? 4'h8 : 4'h7) + {3'h0, ps != sib_pkg::PAR_NONE}
                          + {3'h0, q.async_mode[sib_pkg::SL_BIT]});
    end else if (q.tx_busy && src_tick) begin
      next_q.tx_cnt = q.tx_cnt + 4'h1;
      if (q.tx_cnt == sib_pkg::OVS_LAST) begin
        next_q.tx_sh   = {1'b1, q.tx_sh[11:1]};
        next_q.tx_left = q.tx_left - 4'h1;
        next_q.tx_busy = q.tx_left != 4'h1;
      end
    end
    if (!tx_on) begin
      next_q.tx_busy = 1'b0;
      next_q.tx_sh   = 12'hFFF;
    end

    // three-wire shifter: out on falling edge, in on rising edge
    if (wr_data && tw && !q.tw_busy) begin
      next_q.tw_sh   = reg_bus.wdata;
      next_q.tw_busy = 1'b1;
      next_q.tw_bit  = 4'h0;
      next_q.sck_int = 1'b1;
    end else if (q.tw_busy) begin
      // internal clock toggles each source tick
      if (csck && src_tick) begin
        next_q.sck_int = !q.sck_int;
      end
      if (tw_fall) begin
        next_q.tw_out = q.tw_mode[sib_pkg::DIR_BIT] ? q.tw_sh[0] : q.tw_sh[7];
      end
      if (tw_rise) begin
        sh = q.tw_mode[sib_pkg::DIR_BIT] ? {rx_line, q.tw_sh[7:1]} : {q.tw_sh[6:0], rx_line};
        next_q.tw_sh  = sh;
        next_q.tw_bit = q.tw_bit + 4'h1;
        if (q.tw_bit == 4'h7) begin
          next_q.tw_busy = 1'b0;
          next_q.sck_int = 1'b1;
          next_q.rxbuf   = sh;
          next_q.rx_full = 1'b1;
        end
      end
    end
    if (!tw) begin
      next_q.tw_busy = 1'b0;
      next_q.sck_int = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= sib_pkg::ST_RST;
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata      = q.rdata;
  // clock pin driven only with internal clock
  assign serial_clk_out = q.sck_int;
  assign serial_clk_oe  = tw && csck;
  // cmos output in three-wire and uart transmit
  assign tx_line_out    = uart ? q.tx_sh[0] : q.tw_out;
  assign tx_line_oe     = tx_on || tw;
  assign port_free[0]   = !rx_on;
  assign port_free[1]   = !(tx_on || tw);
  assign port_free[2]   = !tw && !(uart && code == sib_pkg::BAUD_EXT);

  property p_rst_stat;
    @(posedge core_clk) $rose(rstn) |-> q.stat == 3'h0;
  endproperty
  a_rst_stat: assert property (p_rst_stat) else $error("status not clear after reset");

  property p_baud_low;
    @(posedge core_clk) disable iff (!rstn) q.baud[3:0] == 4'h0;
  endproperty
  a_baud_low: assert property (p_baud_low) else $error("baud low bits not zero");

  property p_overrun;
    @(posedge core_clk) disable iff (!rstn)
      rx_done && q.rx_full && !rd_buf |=> q.stat[sib_pkg::OVE_BIT] && q.rx_full;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_frame;
    @(posedge core_clk) disable iff (!rstn)
      rx_done |=> q.stat[sib_pkg::FE_BIT] == !$past(rx_line) && q.rx_st == sib_pkg::RX_IDLE;
  endproperty
  a_frame: assert property (p_frame) else $error("framing flag wrong");

  property p_zero_par;
    @(posedge core_clk) disable iff (!rstn)
      rx_done && ps == sib_pkg::PAR_ZERO |=> !q.stat[sib_pkg::PE_BIT];
  endproperty
  a_zero_par: assert property (p_zero_par) else $error("parity error in zero mode");

  property p_tw_pins;
    @(posedge core_clk) disable iff (!rstn)
      tw |-> tx_line_oe && port_free[0] && serial_clk_oe == csck;
  endproperty
  a_tw_pins: assert property (p_tw_pins) else $error("three-wire pin use wrong");

  property p_start_bit;
    @(posedge core_clk) disable iff (!rstn)
      wr_data && tx_on && !q.tx_busy |=> !tx_line_out && q.tx_busy;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit");

  property p_ext_only_uart;
    @(posedge core_clk) disable iff (!rstn)
      !uart && code == sib_pkg::BAUD_EXT |-> !src_tick && port_free[2] == !tw;
  endproperty
  a_ext_only_uart: assert property (p_ext_only_uart) else $error("external clock used");

  property p_full_hold;
    @(posedge core_clk) disable iff (!rstn)
      q.rx_full && !rd_buf |=> q.rx_full;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("buffer full lost");
endmodule

// ### rtl/sib_pkg.sv
// serial interface package: register map, field positions, state record
// assumes an 8-bit register port with 16-bit addresses
package sib_pkg;
  localparam logic [15:0] OFS_ASYNC = 16'hFF70;
  localparam logic [15:0] OFS_STAT  = 16'hFF71;
  localparam logic [15:0] OFS_3W    = 16'hFF72;
  localparam logic [15:0] OFS_BAUD  = 16'hFF73;
  localparam logic [15:0] OFS_DATA  = 16'hFF74;
  // async mode fields
  localparam int TXE_BIT = 7;
  localparam int RXE_BIT = 6;
  localparam int PS_LSB  = 4;
  localparam int CL_BIT  = 3;
  localparam int SL_BIT  = 2;
  localparam logic [7:0] ASYNC_MASK = 8'hFC;
  // three-wire mode fields
  localparam int CSIE_BIT = 7;
  localparam int DIR_BIT  = 2;
  localparam int CSCK_BIT = 1;
  localparam logic [7:0] TW_MASK = 8'h86;
  // status fields
  localparam int PE_BIT  = 2;
  localparam int FE_BIT  = 1;
  localparam int OVE_BIT = 0;
  // baud control
  localparam logic [7:0] BAUD_MASK = 8'hF0;
  localparam logic [3:0] BAUD_EXT  = 4'h8;
  // parity modes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  // sixteen source clocks per bit, start checked at the middle
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [7:0] REG_RST  = 8'h00;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} sib_rx_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } sib_bus_s;

  typedef struct packed {
    logic [7:0]  async_mode;
    logic [7:0]  tw_mode;
    logic [7:0]  baud;
    logic [2:0]  stat;
    logic [7:0]  rxbuf;
    logic        rx_full;
    logic [7:0]  rdata;
    logic [7:0]  presc;
    logic        ext_q;
    logic        sck_q;
    sib_rx_e     rx_st;
    logic [3:0]  rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic        pe_pend;
    logic [11:0] tx_sh;
    logic [3:0]  tx_left;
    logic [3:0]  tx_cnt;
    logic        tx_busy;
    logic [7:0]  tw_sh;
    logic [3:0]  tw_bit;
    logic        tw_busy;
    logic        tw_out;
    logic        sck_int;
  } sib_state_s;

  // shift clock edge detector starts at the pin's idle high level
  localparam sib_state_s ST_RST = '{tx_sh: 12'hFFF, tw_out: 1'b1, sck_int: 1'b1, sck_q: 1'b1,
                                    rx_st: RX_IDLE, default: '0};
endpackage

// ### verif/sib_core_tb.sv
// testbench for the serial core: registers, pin use, uart receive and send, three-wire
// assumes the peer model on the receive line and a free-running external baud clock
`timescale 1ns/1ps
module sib_core_tb;
  localparam logic [15:0] A_AS = sib_pkg::OFS_ASYNC, A_ST = sib_pkg::OFS_STAT;
  localparam logic [15:0] A_TW = sib_pkg::OFS_3W, A_BD = sib_pkg::OFS_BAUD;
  localparam logic [15:0] A_DT = sib_pkg::OFS_DATA;
  // 8 bits no parity one stop; 8 bits even parity two stops; idle ones after
  localparam logic [11:0] TX_FRAME [2] = '{12'hF4C, 12'hD4C};
  // async, three-wire, baud, then mode error, tx enable, clock enable, free pins
  localparam logic [29:0] MODES [9] = '{
    {8'h00, 8'h00, 8'h00, 6'b000111}, {8'h80, 8'h00, 8'h10, 6'b010101},
    {8'h40, 8'h00, 8'h10, 6'b000110}, {8'hC0, 8'h00, 8'h80, 6'b010000},
    {8'h00, 8'h80, 8'h10, 6'b010001}, {8'h00, 8'h82, 8'h10, 6'b011001},
    {8'h80, 8'h80, 8'h10, 6'b100000}, {8'h00, 8'h80, 8'h80, 6'b100000},
    {8'h80, 8'h00, 8'h90, 6'b100000}};
  logic              core_clk, rstn, rx_line, ext_clk, sclk_out, sclk_oe;
  logic              tx_out, tx_oe, mode_err, p, sclk_ext;
  logic [7:0]        reg_rdata, d;
  logic [2:0]        port_free;
  sib_pkg::sib_bus_s bus;
  int                error_cnt, compares, n;

  sib_core sib_core_i (
    .core_clk(core_clk), .rstn(rstn), .reg_bus(bus), .reg_rdata(reg_rdata),
    .rx_line(rx_line), .ext_baud_clk_pin(ext_clk), .serial_clk_in(sclk_ext),
    .serial_clk_out(sclk_out), .serial_clk_oe(sclk_oe), .tx_line_out(tx_out),
    .tx_line_oe(tx_oe), .port_free(port_free), .mode_err(mode_err));
  sib_peer sib_peer_i (.core_clk(core_clk), .sclk(sclk_oe ? sclk_out : sclk_ext),
                       .rx_line(rx_line));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // one rising edge every four core clocks, off the core edges
  initial begin
    ext_clk = 1'b0;
    #12;
    forever #20 ext_clk = ~ext_clk;
  end

  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic timeout();
    error_cnt++;
    give_verdict();
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input string name, input logic [15:0] a, input logic [7:0] exp);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    @(negedge core_clk);
    chk(name, reg_rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic rx_case(input logic [7:0] v, input logic up, input logic pb, input logic ok,
                         input logic [2:0] st, input logic take);
    sib_peer_i.send(v, up, pb, ok);
    @(posedge core_clk);
    rdchk("status", A_ST, {5'h00, st});
    if (take) rdchk("rx data", A_DT, v);
  endtask
  task automatic wait_sclk(input logic v, inout int cnt);
    while (sclk_out !== v) begin
      @(negedge core_clk);
      cnt++;
      if (cnt > 200) timeout();
    end
  endtask
  task automatic tw_capture(input logic lsb);
    logic [7:0] got;
    int         c;
    for (int i = 0; i < 8; i++) begin
      c = 0;
      wait_sclk(1'b0, c);
      wait_sclk(1'b1, c);
      got[lsb ? i : 7 - i] = tx_out;
      if (i == 1) chk("sclk period", 8'(c), 8'h08);
    end
    chk("tw tx", got, 8'hC5);
  endtask
  // external shift clock: four cycles low, four high, idle high
  task automatic tw_ext_shift(input logic lsb);
    logic [7:0] got;
    for (int i = 0; i < 8; i++) begin
      sclk_ext <= 1'b0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      got[lsb ? i : 7 - i] = tx_out;
      @(posedge core_clk);
      sclk_ext <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
    chk("tw ext tx", got, 8'hC5);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    timeout();
  end
  initial begin
    rstn = 1'b0;
    bus = '0;
    sclk_ext = 1'b1;
    error_cnt = 0;
    compares = 0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdchk("status reset", A_ST, 8'h00);
    rdchk("baud reset", A_BD, 8'h00);
    rdchk("unmapped", 16'hFF7F, 8'h00);
    wr(A_BD, 8'h3F);
    rdchk("baud low bits", A_BD, 8'h30);
    wr(A_ST, 8'h07);
    rdchk("status write", A_ST, 8'h00);
    foreach (MODES[k]) begin
      wr(A_AS, 8'h00);
      wr(A_TW, 8'h00);
      wr(A_BD, MODES[k][13:6]);
      wr(A_AS, MODES[k][29:22]);
      wr(A_TW, MODES[k][21:14]);
      @(negedge core_clk);
      chk("mode err", {7'h00, mode_err}, {7'h00, MODES[k][5]});
      if (!MODES[k][5]) begin
        chk("pins", {3'h0, tx_oe, sclk_oe, port_free}, {3'h0, MODES[k][4:0]});
      end
      @(posedge core_clk);
    end
    wr(A_TW, 8'h00);
    // n of one for the uart receive tests
    wr(A_BD, 8'h10);
    for (int pm = 0; pm < 4; pm++) begin
      d = 8'h5A ^ 8'(pm);
      p = (pm == 3) ? ^d : (pm == 2) ? ~^d : 1'b0;
      wr(A_AS, 8'h48 | 8'(pm << 4));
      rx_case(d, pm != 0, p, 1'b1, 3'b000, 1'b1);
      if (pm != 0) rx_case(d, 1'b1, ~p, 1'b1, {pm[1], 2'b00}, 1'b1);
    end
    wr(A_AS, 8'h48);
    rx_case(8'hC3, 1'b0, 1'b0, 1'b0, 3'b010, 1'b1);
    rx_case(8'h3C, 1'b0, 1'b0, 1'b1, 3'b000, 1'b1);
    wr(A_AS, 8'h4C);
    sib_peer_i.send(8'h11, 1'b0, 1'b0, 1'b1);
    rx_case(8'h22, 1'b0, 1'b0, 1'b1, 3'b001, 1'b0);
    rx_case(8'h33, 1'b0, 1'b0, 1'b1, 3'b001, 1'b1);
    rx_case(8'h44, 1'b0, 1'b0, 1'b1, 3'b000, 1'b1);
    // seven data bits: the eighth sent bit is the stop
    wr(A_AS, 8'h40);
    sib_peer_i.send(8'hAD, 1'b0, 1'b0, 1'b1);
    @(posedge core_clk);
    rdchk("status 7 bit", A_ST, 8'h00);
    rdchk("rx 7 bit", A_DT, 8'h2D);
    wr(A_AS, 8'h00);
    wr(A_BD, 8'h80);
    wr(A_AS, 8'h48);
    rx_case(8'hE7, 1'b0, 1'b0, 1'b1, 3'b000, 1'b1);
    wr(A_AS, 8'h00);
    wr(A_BD, 8'h10);
    for (int f = 0; f < 2; f++) begin
      @(posedge core_clk);
      wr(A_AS, f[0] ? 8'hBC : 8'h88);
      wr(A_DT, 8'hA6);
      n = 0;
      while (tx_out !== 1'b0) begin
        @(negedge core_clk);
        n++;
        if (n > 200) timeout();
      end
      repeat (32) @(negedge core_clk);
      for (int i = 0; i < 12; i++) begin
        chk("tx bit", {7'h00, tx_out}, {7'h00, TX_FRAME[f][i]});
        repeat (64) @(negedge core_clk);
      end
    end
    @(posedge core_clk);
    wr(A_AS, 8'h00);
    // internal clock msb and lsb first, then external clock
    for (int l = 0; l < 4; l++) begin
      wr(A_TW, 8'h80 | (l[0] ? 8'h04 : 8'h00) | (l[1] ? 8'h00 : 8'h02));
      wr(A_DT, 8'hC5);
      fork
        sib_peer_i.tw_drive(8'h3A, l[0]);
        if (l[1]) tw_ext_shift(l[0]);
        else tw_capture(l[0]);
      join
      @(posedge core_clk);
      rdchk("tw rx", A_DT, 8'h3A);
      wr(A_TW, 8'h00);
    end
    give_verdict();
  end
endmodule

// ### verif/sib_peer.sv
// remote serial peer: uart sender and three-wire slave on the receive line
// assumes 64 core clocks per uart bit and a shift clock that idles high
`timescale 1ns/1ps
module sib_peer #(
  parameter int BIT_CYC = 64
) (
  input  wire logic core_clk,
  input  wire logic sclk,
  output logic      rx_line
);
  initial rx_line = 1'b1;
  task automatic hold(input logic v, input int n);
    rx_line = v;
    repeat (n) @(negedge core_clk);
  endtask
  // lsb first, sixteen ticks a bit
  task automatic send(input logic [7:0] d, input logic use_par, input logic par,
                      input logic stop_ok);
    hold(1'b0, BIT_CYC);
    for (int i = 0; i < 8; i++) hold(d[i], BIT_CYC);
    if (use_par) hold(par, BIT_CYC);
    // a broken stop is low only across the sample point
    if (stop_ok) hold(1'b1, BIT_CYC);
    else begin
      hold(1'b0, 40);
      hold(1'b1, BIT_CYC);
    end
  endtask
  // slave bit changes on falling shift clock
  task automatic tw_drive(input logic [7:0] d, input logic lsb_first);
    for (int i = 0; i < 8; i++) begin
      for (int t = 0; t < 200 && sclk !== 1'b0; t++) @(negedge core_clk);
      rx_line = lsb_first ? d[i] : d[7 - i];
      for (int t = 0; t < 200 && sclk !== 1'b1; t++) @(negedge core_clk);
    end
    // hold the last bit past the core's synchronised sample
    @(negedge core_clk);
    rx_line = 1'b1;
  endtask
endmodule
